// ---- core/uhbr_map.vh ----
// Constants for the HID boot report framer
`ifndef UHBR_MAP_VH
`define UHBR_MAP_VH
`define UHBR_EP_CTRL        4'h0
`define UHBR_EP_IN          4'h1
`define UHBR_EP_OUT         4'h2
`define UHBR_ID_CMD_OUT     8'h01
`define UHBR_ID_DATA_OUT    8'h02
`define UHBR_ID_CMD_IN      8'h03
`define UHBR_ID_DATA_IN     8'h04
`define UHBR_MAX_PKT        6'h20
`define UHBR_MAX_XFER       6'h23
`define UHBR_HDR_LEN        6'h03
`define UHBR_CFG_VID_OFS    8'h14
`define UHBR_CFG_PID_OFS    8'h16
`define UHBR_CFG_STR_OFS    8'h18
`define UHBR_LANG_ID        16'h0409
`define UHBR_UNPROG16       16'hffff
`define UHBR_UNPROG32       32'hffffffff
`define UHBR_RPT_USAGE      8'h01
`define UHBR_RPT_LOG_MAX    8'hff
`define UHBR_RPT_SIZE       8'h08
`define UHBR_RPT_COUNT      8'h22
`endif

// ---- core/uhbr_pkt_buf.v ----
// Single-report byte buffer with write and read ports
`timescale 1ns/1ps
module uhbr_pkt_buf (
    input  wire       mclk,
    input  wire       wr_en,
    input  wire [5:0] wr_addr,
    input  wire [7:0] wr_data,
    input  wire [5:0] rd_addr,
    output reg  [7:0] rd_data
);
    reg [7:0] mem [0:34];

    // Registered read, one cycle latency
    always @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// ---- core/uhbr_framer.v ----
// HID boot report framer between USB endpoint engine and packet handler
`timescale 1ns/1ps
`include "uhbr_map.vh"

// Contract
// - No serial framing; USB delimits packets
// - NAK OUT until report can be held
// - Only USB CRC; no extra checksum
// - Exactly endpoints zero, one, two
// - Interrupt OUT endpoint used for flow control
// - Report ids one to four by direction
// - Same layout for every report id
// - Report declared 1,1,0..255,8 bits,34
// - Body at most 34 bytes, packet 32
// - Id, length low, length high, packet bytes
// - Whole transfer at most 35 bytes
// - Length little-endian, packet bytes only
// - Zero length in data phase means abort
// - VID and PID from config area overrides
// - String table pointer selects custom strings
// - String index zero to three selection
module uhbr_framer #(
    parameter [15:0] DEF_VID = 16'h1234, // Arbitrary value
    parameter [15:0] DEF_PID = 16'h0001  // Arbitrary value
) (
    input  wire        mclk,
    input  wire        sys_rst,
    // Endpoint engine side, OUT direction
    input  wire [3:0]  ep_num,
    input  wire        out_valid,
    input  wire [7:0]  out_data,
    input  wire        out_last,
    output wire        out_ready,
    output wire        out_nak,
    // Endpoint engine side, IN direction
    input  wire        in_poll,
    output wire        in_nak,
    output reg         in_valid,
    output reg  [7:0]  in_data,
    output reg         in_last,
    input  wire        in_ready,
    output wire        ep_supported,
    // Packet handler side, received packets
    output reg         rx_valid,
    output reg  [7:0]  rx_data,
    output reg         rx_last,
    output reg         rx_is_data,
    output reg         rx_abort,
    input  wire        rx_ready,
    input  wire        data_phase,
    // Packet handler side, packets to send
    input  wire        tx_valid,
    input  wire [7:0]  tx_data,
    input  wire        tx_last,
    input  wire        tx_is_data,
    output wire        tx_ready,
    // Boot configuration fields and descriptor answers
    input  wire [15:0] vendor_id_override,
    input  wire [15:0] product_id_override,
    input  wire [31:0] string_table_pointer,
    input  wire [1:0]  str_index,
    output reg  [15:0] desc_vid,
    output reg  [15:0] desc_pid,
    output reg         desc_use_table,
    output reg  [31:0] desc_str_addr,
    output reg  [15:0] desc_lang_id,
    output reg  [7:0]  rpt_usage,
    output reg  [7:0]  rpt_log_max,
    output reg  [7:0]  rpt_size,
    output reg  [7:0]  rpt_count
);
    localparam [2:0] S_IDLE = 3'b001;
    localparam [2:0] S_FILL = 3'b010;
    localparam [2:0] S_SEND = 3'b100;

    // Is the report id one the host may send
    function id_ok;
        input [7:0] id;
        begin
            id_ok = (id == `UHBR_ID_CMD_OUT) || (id == `UHBR_ID_DATA_OUT);
        end
    endfunction

    reg  [2:0]  rx_state;
    reg  [5:0]  rx_cnt;
    reg  [7:0]  rx_id;
    reg  [15:0] rx_len;
    reg  [5:0]  fw_ptr;
    reg  [5:0]  fw_end;
    reg         fw_rd;
    // Read fetch in flight, one cycle behind the address
    reg         fw_got;
    wire [15:0] rx_len_now;
    wire [7:0]  rx_buf_q;
    wire        rx_wr;

    reg  [2:0]  tx_state;
    reg  [5:0]  tx_cnt;
    reg  [5:0]  tx_ptr;
    reg         tx_kind;
    reg         tx_rd;
    reg         tx_got;
    // Byte position in the IN report: wait poll, id, length low, rest
    reg  [1:0]  tx_phase;
    wire [7:0]  tx_buf_q;
    wire        tx_wr;

    assign ep_supported = (ep_num == `UHBR_EP_CTRL) || (ep_num == `UHBR_EP_IN) ||
                          (ep_num == `UHBR_EP_OUT);

    assign out_ready = (ep_num == `UHBR_EP_OUT) && (rx_state != S_SEND);
    assign out_nak   = (ep_num == `UHBR_EP_OUT) && (rx_state == S_SEND);
    assign rx_wr     = out_valid && out_ready && (rx_cnt < `UHBR_MAX_XFER);
    // Length at the closing byte; the high byte may still be on the bus
    assign rx_len_now = (rx_cnt == 6'h02) ? {out_data, rx_len[7:0]} : rx_len;

    uhbr_pkt_buf u_rx_buf (
        .mclk    (mclk),
        .wr_en   (rx_wr),
        .wr_addr (rx_cnt),
        .wr_data (out_data),
        .rd_addr (fw_ptr),
        .rd_data (rx_buf_q)
    );

    // OUT report reception and forwarding
    // no framing; no checksum, USB CRC trusted
    always @(posedge mclk) begin
        if (sys_rst) begin
            rx_state   <= S_IDLE;
            rx_cnt     <= 6'h00;
            rx_id      <= 8'h00;
            rx_len     <= 16'h0000;
            fw_ptr     <= 6'h00;
            fw_end     <= 6'h00;
            fw_rd      <= 1'b0;
            fw_got     <= 1'b0;
            rx_valid   <= 1'b0;
            rx_data    <= 8'h00;
            rx_last    <= 1'b0;
            rx_is_data <= 1'b0;
            rx_abort   <= 1'b0;
        end else begin
            rx_abort <= 1'b0;
            case (rx_state)
                S_IDLE, S_FILL: begin
                    if (out_valid && out_ready) begin
                        rx_state <= S_FILL;
                        if (rx_cnt < `UHBR_MAX_XFER) begin
                            rx_cnt <= rx_cnt + 6'h01;
                        end
                        // id, then length low, then high
                        if (rx_cnt == 6'h00) begin
                            rx_id <= out_data;
                        end else if (rx_cnt == 6'h01) begin
                            rx_len[7:0] <= out_data;
                        end else if (rx_cnt == 6'h02) begin
                            rx_len[15:8] <= out_data;
                        end
                        if (out_last) begin
                            rx_cnt   <= 6'h00;
                            rx_state <= S_IDLE;
                            // drop bad id or overlong length
                            if (id_ok(rx_id) && (rx_cnt >= 6'h02) &&
                                (rx_len_now <= {10'h000, `UHBR_MAX_PKT}) &&
                                (rx_len_now <= {10'h000, rx_cnt - 6'h02})) begin
                                // zero length in data phase aborts
                                if (rx_len_now == 16'h0000) begin
                                    rx_abort <= data_phase;
                                end else begin
                                    rx_state   <= S_SEND;
                                    fw_ptr     <= `UHBR_HDR_LEN;
                                    fw_end     <= rx_len_now[5:0] + `UHBR_HDR_LEN - 6'h01;
                                    fw_rd      <= 1'b1;
                                    rx_is_data <= (rx_id == `UHBR_ID_DATA_OUT);
                                end
                            end
                        end
                    end
                end
                S_SEND: begin
                    // Buffer read takes a cycle to address and one to land
                    if (fw_rd) begin
                        fw_rd  <= 1'b0;
                        fw_got <= 1'b1;
                    end else if (fw_got) begin
                        fw_got   <= 1'b0;
                        rx_valid <= 1'b1;
                        rx_data  <= rx_buf_q;
                        rx_last  <= (fw_ptr == fw_end);
                    end else if (rx_valid && rx_ready) begin
                        if (rx_last) begin
                            rx_valid <= 1'b0;
                            rx_last  <= 1'b0;
                            rx_state <= S_IDLE;
                        end else begin
                            rx_valid <= 1'b0;
                            fw_ptr   <= fw_ptr + 6'h01;
                            fw_rd    <= 1'b1;
                        end
                    end
                end
                default: begin
                    rx_state <= S_IDLE;
                end
            endcase
        end
    end

    // Queue takes bytes until full or until a report waits for its poll
    assign tx_ready = (tx_state != S_SEND) && (tx_cnt < `UHBR_MAX_PKT);
    assign tx_wr    = tx_valid && tx_ready;

    uhbr_pkt_buf u_tx_buf (
        .mclk    (mclk),
        .wr_en   (tx_wr),
        .wr_addr (tx_cnt),
        .wr_data (tx_data),
        .rd_addr (tx_ptr),
        .rd_data (tx_buf_q)
    );

    // NAK IN polls until a whole report is queued
    assign in_nak = in_poll && (ep_num == `UHBR_EP_IN) && (tx_state != S_SEND);

    // IN report assembly and delivery
    always @(posedge mclk) begin
        if (sys_rst) begin
            tx_state <= S_IDLE;
            tx_cnt   <= 6'h00;
            tx_ptr   <= 6'h00;
            tx_kind  <= 1'b0;
            tx_rd    <= 1'b0;
            tx_got   <= 1'b0;
            tx_phase <= 2'd0;
            in_valid <= 1'b0;
            in_data  <= 8'h00;
            in_last  <= 1'b0;
        end else begin
            tx_rd <= 1'b0;
            case (tx_state)
                S_IDLE, S_FILL: begin
                    if (tx_wr) begin
                        tx_state <= S_FILL;
                        tx_cnt   <= tx_cnt + 6'h01;
                        tx_kind  <= tx_is_data;
                        // id, length and payload stay within 35 bytes
                        if (tx_last || (tx_cnt == `UHBR_MAX_PKT - 6'h01)) begin
                            tx_state <= S_SEND;
                            tx_ptr   <= 6'h00;
                        end
                    end
                end
                S_SEND: begin
                    // start only on host poll of endpoint one
                    if (tx_phase == 2'd0 && !in_valid && in_poll &&
                        (ep_num == `UHBR_EP_IN)) begin
                        in_valid <= 1'b1;
                        in_last  <= 1'b0;
                        in_data  <= tx_kind ? `UHBR_ID_DATA_IN : `UHBR_ID_CMD_IN;
                        // Pointer wraps to zero on the first payload fetch
                        tx_ptr   <= 6'h3f;
                        tx_phase <= 2'd1;
                    end else if (tx_rd) begin
                        // Address settled, data lands next cycle
                        tx_got <= 1'b1;
                    end else if (tx_got) begin
                        tx_got   <= 1'b0;
                        in_valid <= 1'b1;
                        in_data  <= tx_buf_q;
                        in_last  <= (tx_ptr == tx_cnt - 6'h01);
                    end else if (in_valid && in_ready) begin
                        // Host took the byte on the bus
                        if (in_last) begin
                            in_valid <= 1'b0;
                            in_last  <= 1'b0;
                            tx_cnt   <= 6'h00;
                            tx_phase <= 2'd0;
                            tx_state <= S_IDLE;
                        end else if (tx_phase == 2'd1) begin
                            // length low byte counts packet bytes only
                            in_data  <= {2'b00, tx_cnt};
                            tx_phase <= 2'd2;
                        end else if (tx_phase == 2'd2) begin
                            // high byte is zero, packets stay within 32
                            in_data  <= 8'h00;
                            tx_phase <= 2'd3;
                        end else begin
                            // Drop valid while the next payload byte is fetched
                            in_valid <= 1'b0;
                            tx_rd    <= 1'b1;
                            tx_ptr   <= tx_ptr + 6'h01;
                        end
                    end
                end
                default: begin
                    tx_state <= S_IDLE;
                end
            endcase
        end
    end

    // Descriptor identity from the boot configuration area
    always @(posedge mclk) begin
        if (sys_rst) begin
            desc_vid       <= 16'h0000;
            desc_pid       <= 16'h0000;
            desc_use_table <= 1'b0;
            desc_str_addr  <= 32'h00000000;
            desc_lang_id   <= `UHBR_LANG_ID;
            rpt_usage      <= `UHBR_RPT_USAGE;
            rpt_log_max    <= `UHBR_RPT_LOG_MAX;
            rpt_size       <= `UHBR_RPT_SIZE;
            rpt_count      <= `UHBR_RPT_COUNT;
        end else begin
            // erased fields fall back to defaults
            desc_vid <= (vendor_id_override == `UHBR_UNPROG16) ? DEF_VID : vendor_id_override;
            desc_pid <= (product_id_override == `UHBR_UNPROG16) ? DEF_PID : product_id_override;
            desc_use_table <= (string_table_pointer != `UHBR_UNPROG32) &&
                              (string_table_pointer != 32'h00000000);
            // table entry address per index, 4 bytes each
            desc_str_addr  <= string_table_pointer + {28'h0000000, str_index, 2'b00};
            desc_lang_id   <= `UHBR_LANG_ID;
            rpt_usage   <= `UHBR_RPT_USAGE;
            rpt_log_max <= `UHBR_RPT_LOG_MAX;
            rpt_size    <= `UHBR_RPT_SIZE;
            rpt_count   <= `UHBR_RPT_COUNT;
        end
    end
endmodule

// ---- verification/uhbr_chk.sv ----
// Assertion checker watching the HID boot report framer ports
`timescale 1ns/1ps
module uhbr_chk #(
    parameter [15:0] DEF_VID = 16'h1234,
    parameter [15:0] DEF_PID = 16'h0001
) (
    input wire        mclk, sys_rst,
    input wire [3:0]  ep_num,
    input wire        out_ready, out_nak, in_poll, in_nak, in_valid, in_last, in_ready,
    input wire        ep_supported, rx_valid, rx_last, rx_ready, rx_abort,
    input wire [7:0]  in_data, rx_data, rpt_usage, rpt_log_max, rpt_size, rpt_count,
    input wire [15:0] vendor_id_override, product_id_override, desc_vid, desc_pid,
    input wire [15:0] desc_lang_id
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // A byte offered on either stream and not yet taken
    sequence s_rx_wait; rx_valid && !rx_ready; endsequence
    sequence s_in_wait; in_valid && !in_ready; endsequence
    property p_ep_map; ep_supported == (ep_num <= 4'h2); endproperty
    property p_nak_block; out_nak |-> !out_ready && ep_num == 4'h2; endproperty
    property p_out_ep; out_ready |-> ep_num == 4'h2; endproperty
    property p_in_nak; in_nak |-> in_poll && ep_num == 4'h1 && !in_valid; endproperty
    property p_rx_hold; s_rx_wait |=> rx_valid && $stable(rx_data) && $stable(rx_last); endproperty
    property p_in_hold; s_in_wait |=> in_valid && $stable(in_data) && $stable(in_last); endproperty
    // Abort is a lone pulse and never travels with packet bytes
    property p_abort; rx_abort |-> !rx_valid ##1 !rx_abort; endproperty
    property p_rpt;
        rpt_usage == 8'h01 && rpt_log_max == 8'hff && rpt_size == 8'h08 && rpt_count == 8'h22;
    endproperty
    property p_lang; desc_lang_id == 16'h0409; endproperty
    // Erased field falls back to the built-in identity one cycle later
    property p_vid;
        vendor_id_override != 16'h0000 |=> desc_vid ==
            (($past(vendor_id_override) == 16'hffff) ? DEF_VID : $past(vendor_id_override));
    endproperty
    property p_pid;
        product_id_override != 16'h0000 |=> desc_pid ==
            (($past(product_id_override) == 16'hffff) ? DEF_PID : $past(product_id_override));
    endproperty
    a_ep_map: assert property (p_ep_map) else $error("endpoint support wrong");
    a_nak_block: assert property (p_nak_block) else $error("nak with ready");
    a_out_ep: assert property (p_out_ep) else $error("ready off endpoint two");
    a_in_nak: assert property (p_in_nak) else $error("in nak without poll");
    a_rx_hold: assert property (p_rx_hold) else $error("rx byte dropped");
    a_in_hold: assert property (p_in_hold) else $error("in byte dropped");
    a_abort: assert property (p_abort) else $error("abort pulse wrong");
    a_rpt: assert property (p_rpt) else $error("report fields wrong");
    a_lang: assert property (p_lang) else $error("language id wrong");
    a_vid: assert property (p_vid) else $error("vendor id wrong");
    a_pid: assert property (p_pid) else $error("product id wrong");
endmodule

bind uhbr_framer uhbr_chk #(.DEF_VID(DEF_VID), .DEF_PID(DEF_PID)) u_chk (
    .mclk(mclk), .sys_rst(sys_rst), .ep_num(ep_num), .out_ready(out_ready),
    .out_nak(out_nak), .in_poll(in_poll), .in_nak(in_nak), .in_valid(in_valid),
    .in_last(in_last), .in_ready(in_ready), .ep_supported(ep_supported),
    .rx_valid(rx_valid), .rx_last(rx_last), .rx_ready(rx_ready), .rx_abort(rx_abort),
    .in_data(in_data), .rx_data(rx_data), .rpt_usage(rpt_usage),
    .rpt_log_max(rpt_log_max), .rpt_size(rpt_size), .rpt_count(rpt_count),
    .vendor_id_override(vendor_id_override), .product_id_override(product_id_override),
    .desc_vid(desc_vid), .desc_pid(desc_pid), .desc_lang_id(desc_lang_id));

// ---- verification/uhbr_host.sv ----
// Behavioural USB host and endpoint engine facing the framer
`timescale 1ns/1ps
module uhbr_host (
    input  wire       mclk,
    input  wire       out_ready, in_nak, in_valid, in_last,
    input  wire [7:0] in_data,
    output reg  [3:0] ep_num,
    output reg        out_valid, out_last, in_poll, in_ready,
    output reg  [7:0] out_data
);
    reg [7:0] rcv [0:39];
    integer   rcv_n;
    reg       saw_nak;
    initial begin
        {ep_num, out_valid, out_last, in_poll, in_ready, out_data} = 0;
    end
    task send_rpt(input [7:0] id, input [15:0] len, input [5:0] n, input [7:0] seed);
        integer k;
        begin
            // An idle edge between reports keeps valid from being reassigned
            @(posedge mclk);
            ep_num <= 4'h2;
            for (k = 0; k < n + 3; k = k + 1) begin
                out_valid <= 1'b1;
                out_data <= (k == 0) ? id : (k == 1) ? len[7:0] : (k == 2) ? len[15:8] : seed + k - 3;
                out_last <= (k == n + 2);
                @(posedge mclk);
                while (out_ready !== 1'b1) @(posedge mclk);
            end
            out_valid <= 1'b0;
            out_last <= 1'b0;
            // Released bus shows the inverse, not a stale byte
            out_data <= ~out_data;
        end
    endtask
    // Poll endpoint one, keeping bytes until the last one
    task poll_in(input integer n);
        integer t;
        begin
            rcv_n = 0;
            saw_nak = 1'b0;
            ep_num <= 4'h1;
            in_poll <= 1'b1;
            in_ready <= 1'b1;
            for (t = 0; t < n; t = t + 1) begin
                @(posedge mclk);
                if (in_nak === 1'b1) saw_nak = 1'b1;
                if (in_valid === 1'b1 && rcv_n < 40) begin
                    rcv[rcv_n] = in_data;
                    rcv_n = rcv_n + 1;
                    if (in_last === 1'b1) t = n;
                end
            end
            in_poll <= 1'b0;
            in_ready <= 1'b0;
            ep_num <= 4'h2;
        end
    endtask
endmodule

// ---- verification/tb.sv ----
// Self-checking testbench for the HID boot report framer
`timescale 1ns/1ps
module tb;
    localparam [15:0] TB_VID = 16'h0abc; // Arbitrary value
    localparam [15:0] TB_PID = 16'h0def; // Arbitrary value
    reg         mclk, sys_rst, rx_ready, data_phase, tx_valid, tx_last, tx_is_data;
    reg  [7:0]  tx_data;
    reg  [1:0]  str_index;
    reg  [15:0] vendor_id_override, product_id_override;
    reg  [31:0] string_table_pointer;
    wire [3:0]  ep_num;
    wire        out_valid, out_last, out_ready, out_nak, in_poll, in_nak, in_valid, in_last;
    wire        in_ready, ep_supported, rx_valid, rx_last, rx_is_data, rx_abort, tx_ready;
    wire        desc_use_table;
    wire [7:0]  out_data, in_data, rx_data, rpt_usage, rpt_log_max, rpt_size, rpt_count;
    wire [15:0] desc_vid, desc_pid, desc_lang_id;
    wire [31:0] desc_str_addr;
    integer     n_fail, total_checks, nv, na, k, d;

    uhbr_framer #(.DEF_VID(TB_VID), .DEF_PID(TB_PID)) DUT (
        .mclk(mclk), .sys_rst(sys_rst), .ep_num(ep_num), .out_valid(out_valid),
        .out_data(out_data), .out_last(out_last), .out_ready(out_ready), .out_nak(out_nak),
        .in_poll(in_poll), .in_nak(in_nak), .in_valid(in_valid), .in_data(in_data),
        .in_last(in_last), .in_ready(in_ready), .ep_supported(ep_supported),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .rx_is_data(rx_is_data),
        .rx_abort(rx_abort), .rx_ready(rx_ready), .data_phase(data_phase),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_is_data(tx_is_data),
        .tx_ready(tx_ready), .vendor_id_override(vendor_id_override),
        .product_id_override(product_id_override), .string_table_pointer(string_table_pointer),
        .str_index(str_index), .desc_vid(desc_vid), .desc_pid(desc_pid),
        .desc_use_table(desc_use_table), .desc_str_addr(desc_str_addr),
        .desc_lang_id(desc_lang_id), .rpt_usage(rpt_usage), .rpt_log_max(rpt_log_max),
        .rpt_size(rpt_size), .rpt_count(rpt_count));

    uhbr_host host (
        .mclk(mclk), .out_ready(out_ready), .in_nak(in_nak), .in_valid(in_valid),
        .in_last(in_last), .in_data(in_data), .ep_num(ep_num), .out_valid(out_valid),
        .out_last(out_last), .in_poll(in_poll), .in_ready(in_ready), .out_data(out_data));

    always #25 mclk = ~mclk;

    task chk(input [31:0] got, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    task final_report;
        begin
            if (n_fail == 0 && total_checks > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask

    // Drain packet bytes with the handler stalling every other cycle
    task get_rx(input [5:0] n, input [7:0] seed, input dat);
        integer i, t;
        begin
            i = 0;
            t = 0;
            while (i < n && t < 400) begin
                @(posedge mclk);
                t = t + 1;
                if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
                    chk(rx_data, seed + i);
                    chk(rx_last, i == n - 1);
                    chk(rx_is_data, dat);
                    i = i + 1;
                end
                rx_ready <= t[0];
            end
            chk(i, n);
            rx_ready <= 1'b1;
        end
    endtask

    task watch(input integer n);
        integer i;
        begin
            nv = 0;
            na = 0;
            for (i = 0; i < n; i = i + 1) begin
                @(posedge mclk);
                if (rx_valid === 1'b1) nv = nv + 1;
                if (rx_abort === 1'b1) na = na + 1;
            end
        end
    endtask

    task put_tx(input [5:0] n, input [7:0] seed, input dat);
        integer i;
        begin
            for (i = 0; i < n; i = i + 1) begin
                tx_valid <= 1'b1;
                tx_data <= seed + i;
                tx_last <= (i == n - 1);
                tx_is_data <= dat;
                @(posedge mclk);
                while (tx_ready !== 1'b1) @(posedge mclk);
            end
            tx_valid <= 1'b0;
            tx_last <= 1'b0;
            tx_data <= ~tx_data;
        end
    endtask

    task t_reset;
        begin
            chk({rpt_usage, rpt_log_max, rpt_size, rpt_count}, 32'h01ff0822);
            chk(desc_lang_id, 16'h0409);
            for (k = 0; k < 16; k = k + 1) begin
                host.ep_num <= k;
                @(posedge mclk);
                chk(ep_supported, k <= 2);
            end
        end
    endtask

    // Held report blocks the next OUT, then a full-size data report
    task t_out;
        begin
            rx_ready <= 1'b0;
            host.send_rpt(8'h01, 16'h0002, 2, 8'haa);
            repeat (3) @(posedge mclk);
            chk(out_nak, 1);
            chk(out_ready, 0);
            get_rx(2, 8'haa, 0);
            host.send_rpt(8'h02, 16'h0020, 32, 8'h40);
            get_rx(32, 8'h40, 1);
        end
    endtask

    // Bad id, oversize, short and high-byte lengths are all dropped
    task t_refuse;
        begin
            host.send_rpt(8'h03, 16'h0001, 1, 8'h00);
            host.send_rpt(8'h01, 16'h0021, 32, 8'h00);
            host.send_rpt(8'h02, 16'h0005, 2, 8'h00);
            host.send_rpt(8'h01, 16'h0100, 1, 8'h00);
            watch(30);
            chk(nv, 0);
            host.send_rpt(8'h01, 16'h0001, 1, 8'h77);
            get_rx(1, 8'h77, 0);
        end
    endtask

    task t_abort;
        begin
            data_phase <= 1'b1;
            host.send_rpt(8'h02, 16'h0000, 0, 8'h00);
            watch(10);
            chk(na, 1);
            chk(nv, 0);
            data_phase <= 1'b0;
            host.send_rpt(8'h02, 16'h0000, 0, 8'h00);
            watch(10);
            chk(na, 0);
        end
    endtask

    // Nothing leaves before a poll; id follows packet kind
    task t_in;
        begin
            host.poll_in(20);
            chk(host.saw_nak, 1);
            chk(host.rcv_n, 0);
            for (d = 0; d < 2; d = d + 1) begin
                put_tx(3, 8'h10 + d, d);
                repeat (5) @(posedge mclk);
                chk(in_valid, 0);
                host.poll_in(60);
                chk(host.rcv_n, 6);
                chk(host.rcv[0], 3 + d);
                chk({host.rcv[2], host.rcv[1]}, 16'h0003);
                for (k = 0; k < 3; k = k + 1)
                    chk(host.rcv[3 + k], 8'h10 + d + k);
            end
        end
    endtask

    task t_desc;
        begin
            chk({desc_vid, desc_pid}, {TB_VID, TB_PID});
            chk(desc_use_table, 0);
            vendor_id_override <= 16'h5678;
            product_id_override <= 16'h9abc;
            string_table_pointer <= 32'h00002000;
            repeat (3) @(posedge mclk);
            chk({desc_vid, desc_pid}, 32'h56789abc);
            chk(desc_use_table, 1);
            chk(desc_str_addr, 32'h00002000);
            str_index <= 2'h3;
            repeat (2) @(posedge mclk);
            chk(desc_str_addr, 32'h0000200c);
            string_table_pointer <= 32'hffffffff;
            repeat (3) @(posedge mclk);
            chk(desc_use_table, 0);
        end
    endtask

    initial begin
        {mclk, rx_ready, data_phase, tx_valid, tx_last, tx_is_data, tx_data, str_index} = 0;
        sys_rst = 1'b1;
        vendor_id_override = 16'hffff;
        product_id_override = 16'hffff;
        string_table_pointer = 32'h0;
        n_fail = 0;
        total_checks = 0;
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        t_reset;
        t_out;
        t_refuse;
        t_abort;
        t_in;
        t_desc;
        final_report;
    end

    // Cut a hang short well past the expected run length
    initial begin
        #2000000;
        n_fail = n_fail + 1;
        final_report;
    end
endmodule
